// ### design/oscsel_pkg.sv
package oscsel_pkg;

  // --------------------------------------------------------------------------
  // register map (word offsets on the avalon bus, byte address = 4 * index)
  // --------------------------------------------------------------------------
  localparam logic [3:0] OSC_CTRL_ADDR   = 4'h0;
  localparam logic [3:0] DIV_CTRL_ADDR   = 4'h1;
  localparam logic [3:0] TUNE_CTRL_ADDR  = 4'h2;
  localparam logic [3:0] UNLOCK_ADDR     = 4'h3;

  // --------------------------------------------------------------------------
  // oscillator_control field positions
  // --------------------------------------------------------------------------
  localparam int CUR_SEL_LSB    = 12;
  localparam int NEW_SEL_LSB    = 8;
  localparam int CLK_LOCK_BIT   = 7;
  localparam int PIN_LOCK_BIT   = 6;
  localparam int PLL_LOCK_BIT   = 5;
  localparam int FAIL_BIT       = 3;
  localparam int SEC_EN_BIT     = 1;
  localparam int SWITCH_GO_BIT  = 0;

  // configuration word 2 field positions
  localparam int CFG_PRI_LSB    = 0;
  localparam int CFG_MON_LSB    = 6;
  localparam int CFG_INIT_LSB   = 8;

  // divider and tune fields
  localparam int POSTSCALE_LSB  = 8;
  localparam int TUNE_WIDTH     = 6;

  // reset values and unlock key
  localparam logic [2:0]  POSTSCALE_RST = 3'h1;
  localparam logic [5:0]  TUNE_RST      = 6'h00;
  localparam logic [15:0] UNLOCK_KEY    = 16'h55aa;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ           = 25_000_000;
  localparam int PLL_START_US     = 2;
  localparam int PLL_START_CYC    = (PLL_START_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int SWITCH_SRC_CYC   = 10;

  // source encoding shared by cur and new selection
  localparam logic [2:0] SRC_FRC      = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI      = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
  localparam logic [2:0] SRC_SEC      = 3'h4;
  localparam logic [2:0] SRC_LOWPOWER_RC_OSC     = 3'h5;
  localparam logic [2:0] SRC_RSVD     = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV  = 3'h7;

  // primary sub-mode encoding
  localparam logic [1:0] PRI_EC       = 2'h0;
  localparam logic [1:0] PRI_XT       = 2'h1;
  localparam logic [1:0] PRI_HS       = 2'h2;

  typedef enum logic [1:0] {
    OSCSEL_SW_IDLE,
    OSCSEL_SW_PLL,
    OSCSEL_SW_SETTLE
  } oscsel_sw_t;

  typedef struct packed {
    logic [1:0] primary_mode;
    logic [1:0] switch_monitor;
    logic [2:0] initial_osc;
    logic       osc_out_pin_function;
    logic       pin_lock_oneway;
  } oscsel_cfg_t;

  typedef struct packed {
    logic       primary_osc;
    logic       secondary_osc;
    logic       fast_rc_osc;
    logic       lowpower_rc_osc;
  } oscsel_srcs_t;

endpackage : oscsel_pkg

// ### design/oscsel_top.sv
module oscsel_top #(
  parameter int PLL_START_CYCLES = oscsel_pkg::PLL_START_CYC,
  parameter int SETTLE_CYCLES    = oscsel_pkg::SWITCH_SRC_CYC
) (
  input  wire logic                     ref_clk,              // system clock, 25 MHz
  input  wire logic                     sys_rst,              // async reset, active high
  input  wire logic [15:0]              cfg_word2,            // configuration word 2
  input  wire logic                     cfg_osc_out_function, // primary output pin function bit
  input  wire logic                     cfg_pin_lock_oneway,  // one-way pin map lock bit
  input  wire oscsel_pkg::oscsel_srcs_t src_clk,              // the four raw sources (pins)
  input  wire logic                     pll_locked,           // analog pll lock detect (pin)
  input  wire logic                     clock_fail_detect,    // monitor failure event (pin)
  input  wire logic [3:0]               avs_address,          // avalon word address
  input  wire logic                     avs_read,             // avalon read
  input  wire logic                     avs_write,            // avalon write
  input  wire logic [31:0]              avs_writedata,        // avalon write data
  input  wire logic [3:0]               avs_byteenable,       // avalon byte enables
  output logic [31:0]                   avs_readdata,         // avalon read data
  output logic                          avs_waitrequest,      // avalon wait request
  output logic                          osc_clk,              // selected processor clock
  output logic                          instr_clk,            // osc_clk divided by two
  output logic                          primary_output_pin,   // primary output pin value
  output logic                          primary_output_oe,    // primary output pin enable
  output logic                          pll_enable,           // pll in use
  output logic [2:0]                    postscale_sel,        // fast rc postscaler code
  output logic [5:0]                    fast_rc_tune,         // fast rc trim value
  output logic                          secondary_osc_enable  // secondary oscillator enable
);

  // --------------------------------------------------------------------------
  // configuration capture
  // --------------------------------------------------------------------------
  oscsel_pkg::oscsel_cfg_t cfg;
  logic                    cfg_taken;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg       <= '1;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      cfg.primary_mode         <= cfg_word2[oscsel_pkg::CFG_PRI_LSB +: 2];
      cfg.switch_monitor       <= cfg_word2[oscsel_pkg::CFG_MON_LSB +: 2];
      cfg.initial_osc          <= cfg_word2[oscsel_pkg::CFG_INIT_LSB +: 3];
      cfg.osc_out_pin_function <= cfg_osc_out_function;
      cfg.pin_lock_oneway      <= cfg_pin_lock_oneway;
      cfg_taken                <= 1'b1;
    end
  end

  logic switch_enabled;
  logic monitor_enabled;
  assign switch_enabled  = cfg_taken && !cfg.switch_monitor[1];
  assign monitor_enabled = cfg_taken && (cfg.switch_monitor == 2'b00);

  // --------------------------------------------------------------------------
  // input synchronisers: three stages, change when stages two and three agree
  // --------------------------------------------------------------------------
  logic [2:0] sync_a [6];
  logic [5:0] sync_stable;
  logic [5:0] raw_in;
  assign raw_in = {pll_locked, clock_fail_detect, src_clk.primary_osc, src_clk.secondary_osc,
                   src_clk.fast_rc_osc, src_clk.lowpower_rc_osc};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync_a[gi]      <= 3'h0;
          sync_stable[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= {sync_a[gi][1:0], raw_in[gi]};
          if (sync_a[gi][1] == sync_a[gi][2]) begin
            sync_stable[gi] <= sync_a[gi][2];
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // decoding
  // --------------------------------------------------------------------------
  // pll use
  function automatic logic uses_pll(input logic [2:0] sel);
    uses_pll = (sel == oscsel_pkg::SRC_FRC_PLL) || (sel == oscsel_pkg::SRC_PRI_PLL);
  endfunction : uses_pll

  // initial mode decode; reserved falls back to the erased default
  function automatic logic [2:0] initial_src(input logic [2:0] code);
    if (code == oscsel_pkg::SRC_RSVD) begin
      initial_src = oscsel_pkg::SRC_FRC_DIV;
    end else begin
      initial_src = code;
    end
  endfunction : initial_src

  // --------------------------------------------------------------------------
  // control register state
  // --------------------------------------------------------------------------
  logic [2:0]             cur_osc_sel;
  logic [2:0]             new_osc_sel;
  logic                   clk_sel_lock;
  logic                   pin_map_lock;
  logic                   pll_lock;
  logic                   clock_fail;
  logic                   osc_switch_go;
  logic                   unlocked;
  oscsel_pkg::oscsel_sw_t sw_state;
  logic [15:0]            sw_cnt;

  logic wr_osc;
  logic wr_lo;
  logic wr_hi;
  logic sel_locked;
  assign wr_osc     = avs_write && !avs_waitrequest && (avs_address == oscsel_pkg::OSC_CTRL_ADDR);
  assign wr_lo      = wr_osc && avs_byteenable[0];
  assign wr_hi      = wr_osc && avs_byteenable[1];
  assign sel_locked = monitor_enabled && clk_sel_lock;

  logic switch_start;
  logic switch_done;
  assign switch_start = (sw_state == oscsel_pkg::OSCSEL_SW_IDLE) && osc_switch_go
                        && (new_osc_sel != cur_osc_sel) && (new_osc_sel != oscsel_pkg::SRC_RSVD);
  assign switch_done  = (sw_state == oscsel_pkg::OSCSEL_SW_SETTLE)
                        && (sw_cnt == 16'(SETTLE_CYCLES - 1));

  // unlock key, one write access then closes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      unlocked <= 1'b0;
    end else if (avs_write && !avs_waitrequest) begin
      unlocked <= (avs_address == oscsel_pkg::UNLOCK_ADDR) && (avs_writedata[15:0] == oscsel_pkg::UNLOCK_KEY);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      new_osc_sel <= oscsel_pkg::SRC_FRC_DIV;
    end else if (!cfg_taken) begin
      new_osc_sel <= initial_src(cfg_word2[oscsel_pkg::CFG_INIT_LSB +: 3]);
    end else if (wr_hi && unlocked && !sel_locked) begin
      new_osc_sel <= avs_writedata[oscsel_pkg::NEW_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_osc_sel <= oscsel_pkg::SRC_FRC_DIV;
    end else if (!cfg_taken) begin
      cur_osc_sel <= initial_src(cfg_word2[oscsel_pkg::CFG_INIT_LSB +: 3]);
    end else if (switch_done) begin
      cur_osc_sel <= new_osc_sel;
    end
  end

  // switch go, set by software, cleared by hardware
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_switch_go <= 1'b0;
    end else if (!switch_enabled || switch_done) begin
      osc_switch_go <= 1'b0;
    end else if (sw_state == oscsel_pkg::OSCSEL_SW_IDLE && osc_switch_go && !switch_start) begin
      // redundant or reserved target: aborted
      osc_switch_go <= 1'b0;
    end else if (wr_lo && unlocked && !sel_locked && avs_writedata[oscsel_pkg::SWITCH_GO_BIT]) begin
      osc_switch_go <= 1'b1;
    end
  end

  // switch sequencer: wait for pll on pll targets, then settle cycles of the system clock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_state <= oscsel_pkg::OSCSEL_SW_IDLE;
      sw_cnt   <= 16'h0000;
    end else begin
      case (sw_state)
        oscsel_pkg::OSCSEL_SW_IDLE: begin
          sw_cnt <= 16'h0000;
          if (switch_start) begin
            sw_state <= uses_pll(new_osc_sel) ? oscsel_pkg::OSCSEL_SW_PLL : oscsel_pkg::OSCSEL_SW_SETTLE;
          end
        end
        oscsel_pkg::OSCSEL_SW_PLL: begin
          if (pll_lock) begin
            sw_state <= oscsel_pkg::OSCSEL_SW_SETTLE;
          end
        end
        oscsel_pkg::OSCSEL_SW_SETTLE: begin
          sw_cnt <= sw_cnt + 16'h0001;
          if (switch_done) begin
            sw_state <= oscsel_pkg::OSCSEL_SW_IDLE;
          end
        end
        default: sw_state <= oscsel_pkg::OSCSEL_SW_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pll lock: start-up timer or analog lock
  // --------------------------------------------------------------------------
  logic        pll_target;
  logic [15:0] pll_cnt;
  assign pll_target = uses_pll(cur_osc_sel) || (sw_state != oscsel_pkg::OSCSEL_SW_IDLE && uses_pll(new_osc_sel));

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_cnt  <= 16'h0000;
      pll_lock <= 1'b0;
    end else if (switch_start || !pll_target || !cfg_taken || (switch_done && !uses_pll(new_osc_sel))) begin
      pll_cnt  <= 16'h0000;
      pll_lock <= 1'b0;
    end else begin
      if (pll_cnt != 16'(PLL_START_CYCLES)) begin
        pll_cnt <= pll_cnt + 16'h0001;
      end
      pll_lock <= sync_stable[5] || (pll_cnt == 16'(PLL_START_CYCLES));
    end
  end

  // --------------------------------------------------------------------------
  // lock, fail and enable bits
  // --------------------------------------------------------------------------
  // set-only select lock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_sel_lock <= 1'b0;
    end else if (wr_lo && unlocked && avs_writedata[oscsel_pkg::CLK_LOCK_BIT]) begin
      clk_sel_lock <= 1'b1;
    end
  end

  // fail flag, detection wins over clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_fail <= 1'b0;
    end else if (monitor_enabled && sync_stable[4]) begin
      clock_fail <= 1'b1;
    end else if (switch_start || (wr_lo && !avs_writedata[oscsel_pkg::FAIL_BIT])) begin
      clock_fail <= 1'b0;
    end
  end

  // pin map lock, unlock needed, one-way option
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_map_lock <= 1'b0;
    end else if (wr_lo && unlocked) begin
      if (avs_writedata[oscsel_pkg::PIN_LOCK_BIT] || !(cfg.pin_lock_oneway && pin_map_lock)) begin
        pin_map_lock <= avs_writedata[oscsel_pkg::PIN_LOCK_BIT];
      end
    end
  end

  // divider and tune registers, enable bit
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      postscale_sel        <= oscsel_pkg::POSTSCALE_RST;
      fast_rc_tune         <= oscsel_pkg::TUNE_RST;
      secondary_osc_enable <= 1'b0;
    end else begin
      if (wr_lo && unlocked) begin
        secondary_osc_enable <= avs_writedata[oscsel_pkg::SEC_EN_BIT];
      end
      if (avs_write && !avs_waitrequest && avs_address == oscsel_pkg::DIV_CTRL_ADDR && avs_byteenable[1]) begin
        postscale_sel <= avs_writedata[oscsel_pkg::POSTSCALE_LSB +: 3];
      end
      if (avs_write && !avs_waitrequest && avs_address == oscsel_pkg::TUNE_CTRL_ADDR && avs_byteenable[0]) begin
        fast_rc_tune <= avs_writedata[oscsel_pkg::TUNE_WIDTH-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // avalon slave: one wait cycle, read data valid when waitrequest drops
  // --------------------------------------------------------------------------
  logic [15:0] osc_word;
  assign osc_word = {1'b0, cur_osc_sel, 1'b0, new_osc_sel, clk_sel_lock, pin_map_lock,
                     pll_lock, 1'b0, clock_fail, 1'b0, secondary_osc_enable, osc_switch_go};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        if (avs_address == oscsel_pkg::OSC_CTRL_ADDR) begin
          avs_readdata <= {16'h0000, osc_word};
        end else if (avs_address == oscsel_pkg::DIV_CTRL_ADDR) begin
          avs_readdata <= {21'h000000, postscale_sel, 8'h00};
        end else if (avs_address == oscsel_pkg::TUNE_CTRL_ADDR) begin
          avs_readdata <= {26'h0000000, fast_rc_tune};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // clock selection and instruction clock
  // --------------------------------------------------------------------------
  logic sel_src;
  always_comb begin
    case (cur_osc_sel)
      oscsel_pkg::SRC_PRI, oscsel_pkg::SRC_PRI_PLL: sel_src = sync_stable[3];
      oscsel_pkg::SRC_SEC:                          sel_src = sync_stable[2];
      oscsel_pkg::SRC_LOWPOWER_RC_OSC:                         sel_src = sync_stable[0];
      default:                                      sel_src = sync_stable[1];
    endcase
  end

  logic pri_mode;
  assign pri_mode = (cur_osc_sel == oscsel_pkg::SRC_PRI) || (cur_osc_sel == oscsel_pkg::SRC_PRI_PLL);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_clk            <= 1'b0;
      instr_clk          <= 1'b0;
      pll_enable         <= 1'b0;
      primary_output_pin <= 1'b0;
      primary_output_oe  <= 1'b0;
    end else begin
      osc_clk            <= sel_src;
      if (sel_src && !osc_clk) begin
        instr_clk <= !instr_clk;
      end
      pll_enable         <= pll_target && cfg_taken;
      primary_output_pin <= instr_clk;
      primary_output_oe  <= !pri_mode || cfg.primary_mode != oscsel_pkg::PRI_HS ? !cfg.osc_out_pin_function : 1'b0;
    end
  end

endmodule : oscsel_top

// ### bench/oscsel_checker.sv
module oscsel_checker (
  input wire logic        ref_clk,              // clock
  input wire logic        sys_rst,              // async reset
  input wire logic [15:0] cfg_word2,            // config word
  input wire logic        cfg_osc_out_function, // pin function
  input wire logic [3:0]  avs_address,          // address
  input wire logic        avs_read,             // read
  input wire logic [31:0] avs_readdata,         // read data
  input wire logic        avs_waitrequest,      // wait
  input wire logic        osc_clk,              // selected clock
  input wire logic        instr_clk,            // halved clock
  input wire logic        primary_output_oe,    // pin enable
  input wire logic        primary_output_pin,   // pin value
  input wire logic        pll_enable            // pll in use
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic rd0;
  logic lock_seen;
  logic hs_pri;
  // current source primary while configured for hs
  assign hs_pri = avs_readdata[14:13] == 2'h1 && cfg_word2[1:0] == 2'h2;
  // control register read being answered
  assign rd0 = avs_read && !avs_waitrequest && avs_address == 4'h0;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_seen <= 1'b0;
    end else if (rd0 && avs_readdata[7]) begin
      lock_seen <= 1'b1;
    end
  end
  a_instr_half: assert property ($changed(instr_clk) |-> osc_clk && !$past(osc_clk))
    else $error("instr clock moved without source rise");
  a_rsvd_zero: assert property (rd0 |-> !(avs_readdata[15] | avs_readdata[11] | avs_readdata[4] | avs_readdata[2]))
    else $error("unused bit read as one");
  a_cur_legal: assert property (rd0 |-> avs_readdata[14:12] != 3'h6)
    else $error("current source reads reserved code");
  a_pll_src: assert property (rd0 && !avs_readdata[14] && avs_readdata[12] |-> pll_enable)
    else $error("pll source without pll enable");
  a_lock_pll: assert property (rd0 && avs_readdata[5] |-> pll_enable)
    else $error("lock reported with pll off");
  a_go_held: assert property (rd0 && cfg_word2[7] |-> !avs_readdata[0])
    else $error("switch go set while switching disabled");
  a_pin_oe: assert property (primary_output_oe |-> !cfg_osc_out_function)
    else $error("output pin driven in wrong mode");
  a_hs_pin_off: assert property (rd0 && hs_pri |-> !primary_output_oe)
    else $error("output pin driven in hs primary mode");
  a_pin_instr: assert property (primary_output_pin == $past(instr_clk))
    else $error("output pin does not follow instr clock");
  a_selock_sticky: assert property (rd0 && lock_seen |-> avs_readdata[7])
    else $error("select lock was cleared");
endmodule : oscsel_checker

bind oscsel_top oscsel_checker u_chk (.ref_clk, .sys_rst, .cfg_word2, .cfg_osc_out_function, .avs_address,
  .avs_read, .avs_readdata, .avs_waitrequest, .osc_clk, .instr_clk, .primary_output_oe, .primary_output_pin,
  .pll_enable);

// ### bench/oscsel_src_model.sv
module oscsel_src_model (
  input  wire logic                pll_enable,       // pll requested
  input  wire logic                fail_cmd,         // inject clock failure
  input  wire logic                slow_lock,        // long acquisition
  output oscsel_pkg::oscsel_srcs_t src_clk,          // raw sources
  output logic                     pll_locked,       // lock detect
  output logic                     clock_fail_detect // failure flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p = 1'b0;
  logic s = 1'b0;
  logic f = 1'b0;
  logic l = 1'b0;
  // unrelated periods, each above three system cycles
  always #65 p = ~p;
  always #85 s = ~s;
  always #75 f = ~f;
  always #105 l = ~l;
  assign src_clk = {p, s, f, l};
  assign clock_fail_detect = fail_cmd;
  initial pll_locked = 1'b0;
  always @(pll_enable) begin
    pll_locked = 1'b0;
    if (pll_enable) begin
      #(slow_lock ? 2000 : 200);
      pll_locked = pll_enable;
    end
  end
endmodule : oscsel_src_model

// ### bench/tb_oscillator_source_select.sv
module tb_oscillator_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] cfg_word2 = 16'hffff;
  logic        cfg_osc_out_function = 1'b0;
  logic        cfg_pin_lock_oneway = 1'b0;
  logic        fail_cmd = 1'b0;
  logic        slow_lock = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q, wd;
  logic [31:0] seed = 32'h35;
  logic [2:0]  e, postscale_sel;
  logic [5:0]  fast_rc_tune;
  logic        avs_waitrequest, osc_clk, instr_clk, primary_output_oe, pll_enable, pll_locked, clock_fail_detect;
  logic        secondary_osc_enable;
  logic [2:0]  tgt [8] = '{3'h5, 3'h1, 3'h4, 3'h3, 3'h7, 3'h2, 3'h2, 3'h0};
  oscsel_pkg::oscsel_srcs_t src_clk;
  int          bad_count = 0;
  int          num_checks = 0;

  // short pll timer keeps switch waits brief
  oscsel_top #(.PLL_START_CYCLES(4), .SETTLE_CYCLES(oscsel_pkg::SWITCH_SRC_CYC)) dut (
    .ref_clk, .sys_rst, .cfg_word2, .cfg_osc_out_function, .cfg_pin_lock_oneway, .src_clk, .pll_locked,
    .clock_fail_detect, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .osc_clk, .instr_clk, .primary_output_pin(), .primary_output_oe, .pll_enable,
    .postscale_sel, .fast_rc_tune, .secondary_osc_enable
  );
  oscsel_src_model u_src (.pll_enable, .fail_cmd, .slow_lock, .src_clk, .pll_locked, .clock_fail_detect);

  always #20 ref_clk = ~ref_clk;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // request held until waitrequest is sampled low
  task xfer(input logic r, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    avs_read <= r;
    avs_write <= !r;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      end_sim();
    end
    @(posedge ref_clk);
  endtask : xfer

  task rd(input logic [3:0] a);
    xfer(1'b1, a, 32'h0, 4'hf);
  endtask : rd

  task ctl(input logic [15:0] v);
    xfer(1'b0, oscsel_pkg::UNLOCK_ADDR, {16'h0, oscsel_pkg::UNLOCK_KEY}, 4'hf);
    xfer(1'b0, oscsel_pkg::OSC_CTRL_ADDR, {16'h0, v}, 4'h3);
  endtask : ctl

  task do_reset(input logic [15:0] c);
    sys_rst <= 1'b1;
    cfg_word2 <= c;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  task sw(input logic [2:0] t);
    ctl({5'h0, t, 8'h01});
    for (int n = 0; n < 100; n++) begin
      rd(4'h0);
      if (q[0] === 1'b0) break;
    end
    if (q[0] !== 1'b0) begin
      bad_count++;
      end_sim();
    end
    cmp(32'(q[14:8]), 32'({t, 1'b0, t}));
    cmp(32'(q[5]), 32'(t == 3'h1 || t == 3'h3));
  endtask : sw

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial begin
    do_reset(16'hffff);
    rd(4'h0);
    cmp(32'(q[15:0]), 32'h7700);
    cmp(32'(postscale_sel), 32'(oscsel_pkg::POSTSCALE_RST));
    ctl(16'h0101);
    rd(4'h0);
    cmp(32'(q[0]), 32'h0);
    for (int i = 0; i < 8; i++) begin
      wd = xs();
      cfg_osc_out_function <= wd[8];
      do_reset({5'h0, 3'(i), wd[7:6], 4'h0, ((i == 2) ? 2'h2 : wd[1:0])});
      e = (i == 6) ? 3'h7 : 3'(i);
      rd(4'h0);
      cmp(32'(q[14:8]), 32'({e, 1'b0, e}));
    end
    cfg_pin_lock_oneway <= 1'b1;
    do_reset(16'h0041);
    xfer(1'b0, 4'h0, 32'h0541, 4'h3);
    rd(4'h0);
    cmp(32'(q[15:0]), 32'h0);
    xfer(1'b0, 4'h9, xs(), 4'hf);
    rd(4'h9);
    cmp(q, 32'h0);
    wd = xs();
    xfer(1'b0, oscsel_pkg::DIV_CTRL_ADDR, wd, 4'hf);
    xfer(1'b0, oscsel_pkg::TUNE_CTRL_ADDR, wd, 4'hf);
    rd(oscsel_pkg::DIV_CTRL_ADDR);
    cmp(32'(q[10:8]), 32'(wd[10:8]));
    cmp(32'(postscale_sel), 32'(wd[10:8]));
    rd(oscsel_pkg::TUNE_CTRL_ADDR);
    cmp(32'(q[5:0]), 32'(wd[5:0]));
    cmp(32'(fast_rc_tune), 32'(wd[5:0]));
    ctl(16'h00c2);
    rd(4'h0);
    cmp(32'(q[7:6]), 32'h3);
    cmp(32'(secondary_osc_enable), 32'h1);
    foreach (tgt[k]) sw(tgt[k]);
    rd(4'h0);
    cmp(32'(q[7:6]), 32'h3);
    cfg_pin_lock_oneway <= 1'b0;
    slow_lock <= 1'b1;
    do_reset(16'h0001);
    sw(3'h1);
    fail_cmd <= 1'b1;
    repeat (8) @(posedge ref_clk);
    fail_cmd <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(4'h0);
    cmp(32'(q[3]), 32'h1);
    xfer(1'b0, 4'h0, 32'h8, 4'h1);
    rd(4'h0);
    cmp(32'(q[3]), 32'h1);
    xfer(1'b0, 4'h0, 32'h0, 4'h1);
    rd(4'h0);
    cmp(32'(q[3]), 32'h0);
    ctl(16'h0140);
    ctl(16'h0100);
    rd(4'h0);
    cmp(32'(q[6]), 32'h0);
    ctl(16'h0180);
    ctl(16'h0501);
    rd(4'h0);
    cmp(32'(q[14:8]), 32'h11);
    end_sim();
  end
endmodule : tb_oscillator_source_select
